// File: src/mas_sequencer.sv
// Operation
// - Sixteen-bit results for seven channels
// - Battery mode paces conversions by rate
// - Battery conversion done sets flag, interrupt
// - Low power keeps converter off
// - Supply present: continuous round robin
// - Each channel revisited every 250 ms
// - No done interrupt in continuous mode
// - Results readable any time
// - Voltage scaling full scales 6 and 1.2
// - Input current scale by limit
// - Charge current per mille of setting
//
// Local design decisions: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
module mas_sequencer
	import mas_pkg::*;
#(
	parameter int SLOT_CYC = SLOT_CYC_DEF,
	parameter int RATE1_CYC = CLK_HZ / 1000 * RATE1_MS,
	parameter longint RATE2_CYC = 64'(CLK_HZ) / 1000 * RATE2_MS,
	parameter longint RATE3_CYC = 64'(CLK_HZ) / 1000 * RATE3_MS
)(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Power state pins
	input wire logic supply_present_i,
	input wire logic low_power_select_i,
	// Analog front end
	output logic conv_start_o,
	output logic [2:0] conv_ch_o,
	output logic adc_on_o,
	input wire logic conv_done_i,
	input wire logic [RES_W-1:0] conv_data_i,
	// Interrupt
	output logic irq_o
);
	typedef enum {MAS_IDLE, MAS_CONV} mas_state_t;
	mas_state_t state_r;
	logic [2:0] sup_sync_r, lp_sync_r;
	logic sup_r, lp_r;
	logic [1:0] rate_r, mask_r, stat_r;
	logic trig_r;
	// Wide enough for the slowest battery period
	logic [39:0] tmr_r, period;
	logic [2:0] ch_r;
	logic sweep_cont_r;
	logic [RES_W-1:0] res_r [NUM_CH];
	logic wb_req, rd_stat, irq_nxt;
	logic [7:0] idx;

	// Three-stage pin synchronisers, level after two agree
	always_ff @(posedge clk_i)
	begin
		sup_sync_r <= {sup_sync_r[1:0], supply_present_i};
		lp_sync_r <= {lp_sync_r[1:0], low_power_select_i};
		if (rst_i)
		begin
			sup_r <= 1'b0;
			lp_r <= 1'b0;
		end
		else
		begin
			if (sup_sync_r[2] == sup_sync_r[1])
				sup_r <= sup_sync_r[2];
			if (lp_sync_r[2] == lp_sync_r[1])
				lp_r <= lp_sync_r[2];
		end
	end

	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign rd_stat = wb_req && !wb_we_i && wb_adr_i == OFS_STAT;
	assign idx = (wb_adr_i - OFS_RES0) >> 2;

	// Battery repetition period select
	always_comb
	begin
		case (rate_r)
			2'h1: period = 40'(RATE1_CYC);
			2'h2: period = 40'(RATE2_CYC);
			default: period = 40'(RATE3_CYC);
		endcase
	end

	// Control registers written by software
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rate_r <= CTRL_RATE_RST;
			mask_r <= MASK_RST;
		end
		else if (wb_req && wb_we_i && wb_sel_i[0])
		begin
			if (wb_adr_i == OFS_CTRL)
				rate_r <= wb_dat_i[CTRL_RATE_LSB +: 2];
			if (wb_adr_i == OFS_MASK)
				mask_r <= wb_dat_i[1:0];
		end
	end

	// Sequencer: sweeps all channels, one per slot with supply present, back to back in battery mode
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_r <= MAS_IDLE;
			tmr_r <= '0;
			ch_r <= CH_VIN;
			trig_r <= 1'b0;
			sweep_cont_r <= 1'b0;
			conv_start_o <= 1'b0;
			conv_ch_o <= CH_VIN;
			adc_on_o <= 1'b0;
		end
		else
		begin
			conv_start_o <= 1'b0;
			if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == OFS_CTRL
				&& wb_dat_i[CTRL_TRIG_BIT])
				trig_r <= 1'b1;
			adc_on_o <= sup_r || lp_r;
			if (tmr_r != 0)
				tmr_r <= tmr_r - 40'h1;
			case (state_r)
				MAS_IDLE:
				begin
					if (sup_r && tmr_r == 0)
					begin
						state_r <= MAS_CONV;
						sweep_cont_r <= 1'b1;
						conv_start_o <= 1'b1;
						conv_ch_o <= ch_r;
						tmr_r <= 40'(SLOT_CYC - 1);
					end
					else if (!sup_r && lp_r && ch_r == CH_VIN &&
						(rate_r == RATE_MANUAL ? trig_r : tmr_r == 0))
					begin
						state_r <= MAS_CONV;
						sweep_cont_r <= 1'b0;
						trig_r <= 1'b0;
						conv_start_o <= 1'b1;
						conv_ch_o <= ch_r;
						tmr_r <= rate_r == RATE_MANUAL ? 40'h0 : period;
					end
					else if (!sup_r && lp_r && ch_r != CH_VIN)
					begin
						state_r <= MAS_CONV;
						conv_start_o <= 1'b1;
						conv_ch_o <= ch_r;
					end
					else if (!sup_r && !lp_r)
					begin
						ch_r <= CH_VIN;
						trig_r <= 1'b0;
					end
				end
				MAS_CONV:
				begin
					if (conv_done_i)
					begin
						state_r <= MAS_IDLE;
						ch_r <= ch_r == CH_AUX ? CH_VIN : ch_r + 3'h1;
					end
				end
				default: state_r <= MAS_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			for (int i = 0; i < NUM_CH; i++)
				res_r[i] <= '0;
		end
		else if (state_r == MAS_CONV && conv_done_i)
			res_r[ch_r] <= conv_data_i;
	end

	// sticky status, read clears, set wins
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			stat_r <= '0;
		else
		begin
			if (rd_stat)
				stat_r <= '0;
			if (state_r == MAS_CONV && conv_done_i && ch_r == CH_AUX
				&& !sweep_cont_r)
				stat_r[ST_DONE_BIT] <= 1'b1;
			if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == OFS_CTRL
				&& wb_dat_i[CTRL_TRIG_BIT] && trig_r)
				stat_r[ST_SKIP_BIT] <= 1'b1;
		end
	end

	// Interrupt level from registered status
	assign irq_nxt = |(stat_r & ~mask_r);
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= irq_nxt;
	end

	// bus read path, ack one cycle later
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end
		else
		begin
			wb_ack_o <= wb_req;
			wb_dat_o <= '0;
			if (wb_req && !wb_we_i)
			begin
				if (wb_adr_i == OFS_CTRL)
					wb_dat_o <= {26'h0, rate_r, 3'h0, trig_r};
				else if (wb_adr_i == OFS_STAT)
					wb_dat_o <= {30'h0, stat_r};
				else if (wb_adr_i == OFS_MASK)
					wb_dat_o <= {30'h0, mask_r};
				else if (wb_adr_i == OFS_MODE)
					wb_dat_o <= {29'h0, adc_on_o, lp_r, sup_r};
				else if (wb_adr_i >= OFS_RES0 && idx < 8'(NUM_CH))
					wb_dat_o <= {16'h0, res_r[idx[2:0]]};
			end
		end
	end

	chk_done_irq: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(stat_r[ST_DONE_BIT]) && !mask_r[0] |=> irq_o)
		else $error("done flag did not raise irq");
	// no done flag from continuous sweep
	chk_cont_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
		sweep_cont_r && state_r == MAS_CONV && conv_done_i && !rd_stat
		|=> stat_r[ST_DONE_BIT] == $past(stat_r[ST_DONE_BIT]))
		else $error("done flag set in continuous mode");
	// no start while in low power
	chk_lp_off: assert property (@(posedge clk_i) disable iff (rst_i)
		!sup_r && !lp_r && state_r == MAS_IDLE |=> !conv_start_o)
		else $error("conversion in low power");
	chk_manual_trig: assert property (@(posedge clk_i) disable iff (rst_i)
		!sup_r && lp_r && rate_r == RATE_MANUAL && state_r == MAS_IDLE
		&& ch_r == CH_VIN && !trig_r |=> !conv_start_o)
		else $error("manual start without trigger");
	chk_res_whole: assert property (@(posedge clk_i) disable iff (rst_i)
		!(state_r == MAS_CONV && conv_done_i) |=> $stable(res_r[0]))
		else $error("result changed without capture");
	chk_bus_ack: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus ack timing wrong");
	// continuous sweep starts when slot elapsed
	chk_cont_run: assert property (@(posedge clk_i) disable iff (rst_i)
		sup_r && state_r == MAS_IDLE && tmr_r == 0 |=> conv_start_o)
		else $error("continuous sweep stalled");
	chk_slot_gap: assert property (@(posedge clk_i) disable iff (rst_i)
		sup_r && conv_start_o && $past(state_r == MAS_IDLE)
		|-> tmr_r == 40'(SLOT_CYC - 1))
		else $error("slot spacing wrong");
endmodule : mas_sequencer

// File: src/mas_pkg.sv
package mas_pkg;
	// Channel indices in round-robin order
	localparam int NUM_CH = 7;
	localparam logic [2:0] CH_VIN = 3'h0;
	localparam logic [2:0] CH_IIN = 3'h1;
	localparam logic [2:0] CH_RAIL = 3'h2;
	localparam logic [2:0] CH_VBAT = 3'h3;
	localparam logic [2:0] CH_ICHG = 3'h4;
	localparam logic [2:0] CH_THERM = 3'h5;
	localparam logic [2:0] CH_AUX = 3'h6;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_MASK = 8'h08;
	localparam logic [7:0] OFS_MODE = 8'h0C;
	localparam logic [7:0] OFS_RES0 = 8'h20;
	// Control fields
	localparam int CTRL_TRIG_BIT = 0;
	localparam int CTRL_RATE_LSB = 4;
	localparam logic [1:0] RATE_MANUAL = 2'h0;
	localparam logic [1:0] CTRL_RATE_RST = 2'h0;
	localparam logic [1:0] MASK_RST = 2'h3;
	// Status bits: done, trigger written while one still pending
	localparam int ST_DONE_BIT = 0;
	localparam int ST_SKIP_BIT = 1;
	// Timing
	localparam int CLK_HZ = 40000000;
	localparam int SWEEP_MS = 250;
	localparam int SWEEP_CYC = CLK_HZ / 1000 * SWEEP_MS;
	localparam int SLOT_CYC_DEF = SWEEP_CYC / NUM_CH;
	// Battery rates in ms for codes 1..3
	localparam int RATE1_MS = 1000;
	localparam int RATE2_MS = 60000;
	localparam int RATE3_MS = 1800000;
	// Scaling: full scale in mV / uA, charge fraction per mille
	localparam int FS_VOLT_MV = 6000;
	localparam int FS_LOWV_MV = 1200;
	localparam int FS_IIN_LO_UA = 375000;
	localparam int FS_IIN_HI_UA = 750000;
	localparam int INPUT_CURRENT_LIMIT_SPLIT_MA = 150;
	localparam int ICHG_DEN_PERMILLE = 800;
	localparam int RES_W = 16;
endpackage : mas_pkg

// File: tb/mas_adc_model.sv
`timescale 1ns/1ps
// Converter stand-in, answers each start after 1 to 8 cycles
module mas_adc_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Sequencer side
	input wire logic start_i,
	input wire logic [2:0] ch_i,
	output logic done_o,
	output logic [15:0] data_o
);
	logic busy_r;
	logic [2:0] ch_r;
	logic [12:0] seq_r;
	int wait_r;
	// Data toggles while not valid, so a stale value never holds for two cycles
	always @(posedge clk_i)
	begin
		done_o <= 1'b0;
		data_o <= ~data_o;
		if (rst_i)
		begin
			busy_r <= 1'b0;
			seq_r <= 13'h0;
			data_o <= 16'h0;
		end
		else if (start_i)
		begin
			busy_r <= 1'b1;
			ch_r <= ch_i;
			wait_r <= $urandom_range(8, 1);
		end
		else if (busy_r && wait_r == 1)
		begin
			done_o <= 1'b1;
			data_o <= {ch_r, seq_r};
			seq_r <= seq_r + 13'h1;
			busy_r <= 1'b0;
		end
		else
			wait_r <= wait_r - 1;
	end
endmodule : mas_adc_model

// File: tb/mas_sequencer_tb.sv
`timescale 1ns/1ps
module mas_sequencer_tb
	import mas_pkg::*;
;
	localparam int SLOT = 20;
	logic clk_i = 1'b0, rst_i = 1'b1, supply = 1'b0, lp = 1'b0;
	logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h0;
	logic [31:0] wb_dat = 32'h0, rdat, q, r;
	logic ack, start, adc_on, done, irq;
	logic [2:0] ch, last_ch;
	logic [15:0] data, res_exp [7], prv [7];
	int fail_count = 0, num_checks = 0, starts = 0, rr_n = 0, cyc_n = 0;
	int last_cyc, i;
	bit rr_on = 1'b0;
	initial forever #12.5 clk_i = ~clk_i;
	mas_sequencer #(.SLOT_CYC(SLOT), .RATE1_CYC(50), .RATE2_CYC(100),
		.RATE3_CYC(200)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .supply_present_i(supply),
		.low_power_select_i(lp), .conv_start_o(start), .conv_ch_o(ch),
		.adc_on_o(adc_on), .conv_done_i(done), .conv_data_i(data),
		.irq_o(irq));
	mas_adc_model u_adc (.clk_i(clk_i), .rst_i(rst_i), .start_i(start),
		.ch_i(ch), .done_o(done), .data_o(data));
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// Verdict
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_sim
	// Bounded wait on a flag
	task automatic wait_hi(ref logic s, input int lim);
		for (int n = 0; s !== 1'b1; n++)
		begin
			if (n > lim)
			begin
				chk(32'h0, 32'h1);
				end_sim();
			end
			@(posedge clk_i);
		end
	endtask : wait_hi
	// Classic Wishbone cycle, then one idle cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		{wb_cyc, wb_stb, wb_we} <= {2'b11, w};
		wb_adr <= a;
		wb_dat <= d;
		@(posedge clk_i);
		wait_hi(ack, 16);
		q = rdat;
		{wb_cyc, wb_stb, wb_we} <= 3'h0;
		@(posedge clk_i);
	endtask : wb
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(q, e);
	endtask : rd
	// Result read, either the latest or the previous whole value
	task automatic rres(input int k);
		wb(1'b0, OFS_RES0 + 8'(4 * k), 32'h0);
		chk(q, {16'h0, (q[15:0] === prv[k]) ? prv[k] : res_exp[k]});
	endtask : rres
	// Start monitor: order, spacing, expected results
	always @(posedge clk_i)
	begin
		cyc_n <= cyc_n + 1;
		if (done === 1'b1)
		begin
			prv[last_ch] <= res_exp[last_ch];
			res_exp[last_ch] <= data;
		end
		if (start === 1'b1)
		begin
			starts <= starts + 1;
			if (rr_on && rr_n > 0)
			begin
				chk(ch, (last_ch + 1) % 7);
				chk(cyc_n - last_cyc, SLOT);
			end
			rr_n <= rr_on ? rr_n + 1 : 0;
			last_ch <= ch;
			last_cyc <= cyc_n;
		end
	end
	// Main sequence
	initial
	begin
		void'($urandom(32'h05866b98));
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(OFS_MASK, 32'(MASK_RST));
		rd(8'hF0, 32'h0);
		for (i = 0; i < 4; i++)
		begin
			r = $urandom;
			wb(1'b1, OFS_MASK, r);
			rd(OFS_MASK, {30'h0, r[1:0]});
		end
		wb(1'b1, OFS_CTRL, 32'h10);
		repeat (150) @(posedge clk_i);
		chk(starts, 0);
		chk(adc_on, 0);
		wb(1'b1, OFS_CTRL, 32'h0);
		wb(1'b1, OFS_MASK, 32'h0);
		lp <= 1'b1;
		repeat (80) @(posedge clk_i);
		chk(starts, 0);
		wb(1'b1, OFS_CTRL, 32'h1);
		wait_hi(irq, 400);
		chk(starts, 7);
		rd(OFS_STAT, 32'h1);
		@(posedge clk_i);
		chk(irq, 0);
		for (i = 0; i < 7; i++)
			rres(i);
		for (i = 1; i < 4; i++)
		begin
			wb(1'b1, OFS_CTRL, 32'(i) << 4);
			wait_hi(irq, 120 << i);
			rd(OFS_STAT, 32'h1);
		end
		wb(1'b1, OFS_MASK, 32'h1);
		repeat (300) @(posedge clk_i);
		chk(irq, 0);
		rd(OFS_STAT, 32'h1);
		wb(1'b1, OFS_MASK, 32'h0);
		wb(1'b1, OFS_CTRL, 32'h0);
		supply <= 1'b1;
		repeat (150) @(posedge clk_i);
		wb(1'b0, OFS_STAT, 32'h0);
		rr_on = 1'b1;
		for (i = 0; i < 21; i++)
		begin
			repeat (SLOT) @(posedge clk_i);
			rres(i % 7);
		end
		chk(rr_n > 14, 1);
		chk(irq, 0);
		rd(OFS_STAT, 32'h0);
		rd(OFS_MODE, 32'h7);
		end_sim();
	end
endmodule : mas_sequencer_tb
